// File: pkg/qdsp_pkg.sv
// Package: constants, carriers and states for the quad DAC serial pin control
package qdsp_pkg;

	localparam int NUM_CH     = 4;   // DAC channels
	localparam int FRAME_BITS = 24;  // Input shift register width
	localparam int CODE_W     = 16;  // Channel code width
	localparam int CNT_W      = 5;   // Bit counter width

	localparam logic [CNT_W-1:0]  FRAME_LEN    = 5'h18;    // Bits per frame
	localparam logic [CODE_W-1:0] CODE_ZERO    = 16'h0000; // Zero scale
	localparam logic [CODE_W-1:0] CODE_MID_16  = 16'h8000; // Midscale, 16-bit variant
	localparam logic [CODE_W-1:0] CODE_MID_12  = 16'h0800; // Midscale, 12-bit variant
	localparam logic [CODE_W-1:0] CODE_MASK_16 = 16'hFFFF; // Codes 0 to 65535
	localparam logic [CODE_W-1:0] CODE_MASK_12 = 16'h0FFF; // Codes 0 to 4095

	typedef logic [FRAME_BITS-1:0] qdsp_word_t;  // One captured frame
	typedef logic [CODE_W-1:0]     qdsp_code_t;  // One channel code

	// Channel write request from the command decoder
	typedef struct packed {
		logic              valid;    // One-cycle request
		logic [NUM_CH-1:0] chanMask; // Channels addressed
		logic              update;   // Also move pending code to DAC register; written code waits
		qdsp_code_t        code;     // Straight binary code
	} qdsp_wr_t;

	// Pin bundle that crosses into the system clock
	typedef struct packed {
		logic sclk;     // Serial clock
		logic frameN;   // Frame sync, active low
		logic dataIn;   // Serial data in
		logic loadN;    // Load strobe, active low
		logic resetN;   // Reset pin, active low
		logic levelSel; // Reset level select
		logic span;     // Span select
	} qdsp_pins_t;

	// Idle pin values; reset pin idles low so power-on waits for a real high
	localparam qdsp_pins_t PIN_IDLE = '{sclk: 1'b1, frameN: 1'b1, dataIn: 1'b0,
		loadN: 1'b1, resetN: 1'b0, levelSel: 1'b0, span: 1'b0};

	typedef enum logic {FR_IDLE, FR_SHIFT} qdsp_frame_t;  // Frame states
	typedef enum logic {POR_WAIT, POR_RUN} qdsp_por_t;    // Power-on states

endpackage : qdsp_pkg

// File: rtl/qdsp_sync2.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module qdsp_sync2 #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// Levels
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);

	logic [W-1:0] meta_r;  // First stage, read by second only

	// Two stages, reset to idle levels
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_r <= INIT;
			q      <= INIT;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : qdsp_sync2

// File: rtl/qdsp_chan_reg.sv
// One channel: input register, DAC register and new-data flag
`timescale 1ns/1ns
module qdsp_chan_reg
	import qdsp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Reset load
	input  wire logic       loadRst,
	input  wire qdsp_code_t rstCode,
	// Write and transfer
	input  wire logic       writeEn,
	input  wire qdsp_code_t writeCode,
	input  wire logic       xferEn,
	// State
	output qdsp_code_t      inputCode,
	output qdsp_code_t      dacCode,
	output logic            pending
);

	// Reset load first, then write and copy; a write beats the flag clear
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			inputCode <= CODE_ZERO;
			dacCode   <= CODE_ZERO;
			pending   <= 1'b0;
		end else if (loadRst) begin
			inputCode <= rstCode;
			dacCode   <= rstCode;
			pending   <= 1'b0;
		end else begin
			if (writeEn)
				inputCode <= writeCode;
			if (xferEn && pending)
				dacCode <= inputCode;
			if (writeEn)
				pending <= 1'b1;
			else if (xferEn)
				pending <= 1'b0;
		end
	end

endmodule : qdsp_chan_reg

// File: rtl/qdsp_serial_ctrl.sv
// Quad DAC serial frame, load strobe, reset and span pin control
`timescale 1ns/1ns
// Behaviour
// - Frame low: one bit per falling edge, 24 bits
// - 24-bit shift register fed on falling edges
// - Serial output changes on rising clock edge
// - Serial output carries readback or daisy data
// - Load strobe copies new input codes together
// - Load strobe works pulsed or held low
// - Span select sets all four spans together
// - Reset pin acts on its falling edge
// - Load strobe ignored while reset pin low
// - Reset loads zero or midscale per select
// - Power-up code follows reset level select
// - Power-up waits while reset pin is low
// - Codes straight binary, 12 or 16 bits
module qdsp_serial_ctrl
	import qdsp_pkg::*;
(
	// System clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    rst_n,
	// Serial link pins
	input  wire logic                    sclk,
	input  wire logic                    frameSyncN,
	input  wire logic                    serial_data_in,
	output logic                         serial_data_out,
	// Strobe and level pins
	input  wire logic                    load_dac_n,
	input  wire logic                    resetPinN,
	input  wire logic                    reset_level_select,
	input  wire logic                    spanSelect,
	input  wire logic                    variant12,
	// Command decoder side
	output logic                         wordValid,
	output qdsp_word_t                   wordData,
	input  wire qdsp_wr_t                chanWrite,
	input  wire logic                    readbackLoad,
	input  wire qdsp_word_t              readbackWord,
	// Channel outputs
	output qdsp_code_t [NUM_CH-1:0]      dacCode,
	output logic [NUM_CH-1:0]            inputPending,
	output logic                         spanDouble,
	output logic                         porDone
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	qdsp_pins_t pinsRaw;   // Raw pin bundle
	qdsp_pins_t pinsSync;  // Pins after two flops
	qdsp_pins_t pinsPrev_r; // Pins one cycle later

	assign pinsRaw = '{sclk: sclk, frameN: frameSyncN, dataIn: serial_data_in,
		loadN: load_dac_n, resetN: resetPinN, levelSel: reset_level_select,
		span: spanSelect};

	// Two-flop crossing of every pin
	qdsp_sync2 #(
		.W    ($bits(qdsp_pins_t)),
		.INIT (PIN_IDLE)
	) uSync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       (pinsRaw),
		.q       (pinsSync)
	);

	// Delayed copy for edge finding
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pinsPrev_r <= PIN_IDLE;
		else
			pinsPrev_r <= pinsSync;
	end

	wire sclkFall  = pinsPrev_r.sclk & ~pinsSync.sclk;      // Serial clock fell
	wire sclkRise  = ~pinsPrev_r.sclk & pinsSync.sclk;      // Serial clock rose
	wire frameFall = pinsPrev_r.frameN & ~pinsSync.frameN;  // Frame opened
	wire frameRise = ~pinsPrev_r.frameN & pinsSync.frameN;  // Frame closed
	wire resetFall = pinsPrev_r.resetN & ~pinsSync.resetN;  // Reset pin fell

	////////////////////////////////////////////////////////////////////////////
	// Frame state machine and bit counter

	qdsp_frame_t       frState_r;    // Frame state
	qdsp_frame_t       frState_nxt;  // Next frame state
	logic [CNT_W-1:0]  bitCnt_r;     // Bits captured this frame
	logic [CNT_W-1:0]  bitCnt_nxt;   // Next bit count

	wire inFrame  = (frState_r == FR_SHIFT);          // Frame open
	wire frameFull = (bitCnt_r == FRAME_LEN);          // All bits taken
	wire shiftEn  = inFrame & sclkFall & ~frameFull;  // Capture a bit

	// Next state and count
	always_comb begin
		frState_nxt = frState_r;
		bitCnt_nxt  = bitCnt_r;
		unique case (frState_r)
			FR_IDLE: begin
				// Frame sync low starts counting
				if (frameFall) begin
					frState_nxt = FR_SHIFT;
					bitCnt_nxt  = '0;
				end
			end
			FR_SHIFT: begin
				// Rising sync ends the frame; extra edges are ignored
				if (frameRise)
					frState_nxt = FR_IDLE;
				else if (shiftEn)
					bitCnt_nxt = bitCnt_r + 1'b1;
			end
		endcase
	end

	// Frame state registers
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			frState_r <= FR_IDLE;
			bitCnt_r  <= '0;
		end else begin
			frState_r <= frState_nxt;
			bitCnt_r  <= bitCnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift register, serial output and word hand-off

	qdsp_word_t shiftReg_r;  // Input shift register
	logic       sdo_r;       // Serial output flop

	wire sdoUpdate  = (inFrame & sclkRise) | frameFall;       // Output moves here
	wire wordDone   = inFrame & frameRise & frameFull;        // Full frame closed
	wire rbLoadOk   = readbackLoad & ~inFrame;                // Readback between frames

	// Shift on falling edges; readback word loads only between frames
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			shiftReg_r <= '0;
		else if (shiftEn)
			shiftReg_r <= {shiftReg_r[FRAME_BITS-2:0], pinsSync.dataIn};
		else if (rbLoadOk)
			shiftReg_r <= readbackWord;
	end

	// Oldest bit goes out on rising edges, ready for the next falling edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			sdo_r <= 1'b0;
		else if (sdoUpdate)
			sdo_r <= shiftReg_r[FRAME_BITS-1];
	end

	assign serial_data_out = sdo_r;

	// Word hand-off pulse on the closing edge of a full frame
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wordValid <= 1'b0;
			wordData  <= '0;
		end else begin
			wordValid <= wordDone;
			if (wordDone)
				wordData <= shiftReg_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-on sequence and reset pin

	qdsp_por_t  porState_r;  // Power-on state
	qdsp_code_t resetCode;   // Zero or midscale
	qdsp_code_t codeMask;    // Variant code range
	qdsp_code_t midCode;     // Variant midscale

	assign midCode   = variant12 ? CODE_MID_12 : CODE_MID_16;
	assign codeMask  = variant12 ? CODE_MASK_12 : CODE_MASK_16;
	assign resetCode = pinsSync.levelSel ? midCode : CODE_ZERO;

	wire porRelease = (porState_r == POR_WAIT) & pinsSync.resetN;
	wire loadRst    = porRelease | ((porState_r == POR_RUN) & resetFall);

	// Stay in wait until the reset pin is seen high
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			porState_r <= POR_WAIT;
		else if (porRelease)
			porState_r <= POR_RUN;
	end

	assign porDone = (porState_r == POR_RUN);

	////////////////////////////////////////////////////////////////////////////
	// Load strobe, writes and channel registers

	logic [NUM_CH-1:0] chanXfer;   // Per-channel copy enable
	logic [NUM_CH-1:0] chanWr;     // Per-channel write enable
	qdsp_code_t [NUM_CH-1:0] inputCodes; // Input register contents
	qdsp_code_t writeCode;         // Code cut to variant range

	// Strobe level low copies; pulsed or tied low both work, reset pin low blocks it
	wire strobeGo = porDone & pinsSync.resetN & ~pinsSync.loadN;
	wire wrOk     = porDone & chanWrite.valid;                    // Writes after power-on

	assign writeCode = chanWrite.code & codeMask;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : gChan
			assign chanWr[gi]   = wrOk & chanWrite.chanMask[gi];
			assign chanXfer[gi] = strobeGo | (chanWr[gi] & chanWrite.update);

			// Channel register pair
			qdsp_chan_reg uChan (
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.loadRst   (loadRst),
				.rstCode   (resetCode),
				.writeEn   (chanWr[gi]),
				.writeCode (writeCode),
				.xferEn    (chanXfer[gi]),
				.inputCode (inputCodes[gi]),
				.dacCode   (dacCode[gi]),
				.pending   (inputPending[gi])
			);
		end
	endgenerate

	// One span bit drives all channels
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			spanDouble <= 1'b0;
		else
			spanDouble <= pinsSync.span;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Counter never passes the frame length
	chk_frame_bits: assert property (inFrame |-> bitCnt_r <= FRAME_LEN)
		else $error("bit count beyond frame length");

	// Each captured bit advances the count by one
	chk_bit_count: assert property (shiftEn && !frameRise |=>
		bitCnt_r == CNT_W'($past(bitCnt_r) + 1'b1))
		else $error("bit count did not advance");

	// Captured bit lands in the low end
	chk_shift_capture: assert property (shiftEn |=>
		shiftReg_r[0] == $past(pinsSync.dataIn) && shiftReg_r[FRAME_BITS-1:1] ==
		$past(shiftReg_r[FRAME_BITS-2:0]))
		else $error("shift register did not take the bit");

	// Output moves only after a rising edge or frame start
	chk_sdo_edge: assert property ($changed(serial_data_out) |-> $past(sdoUpdate))
		else $error("serial output changed off its edge");

	// Output carries the oldest shifted bit
	chk_daisy_bit: assert property (inFrame && sclkRise |=>
		serial_data_out == $past(shiftReg_r[FRAME_BITS-1]))
		else $error("serial output not the oldest bit");

	// Copy moves the pending input code to the DAC register
	chk_strobe_copy: assert property (chanXfer[0] && inputPending[0] && !loadRst |=>
		dacCode[0] == $past(inputCodes[0]) && (!inputPending[0] || $past(chanWr[0])))
		else $error("load strobe did not copy channel zero");

	// Held-low strobe copies pending data within one cycle
	chk_strobe_held: assert property (!pinsSync.loadN && pinsSync.resetN && porDone &&
		inputPending[1] && !chanWr[1] && !loadRst |=> !inputPending[1])
		else $error("held strobe left data pending");

	// Span follows its pin one cycle later for all channels
	chk_span_all: assert property (spanDouble == $past(pinsSync.span))
		else $error("span output does not follow the pin");

	// Falling reset pin loads the reset code into both registers
	chk_reset_load: assert property (porDone && resetFall |=>
		dacCode[2] == $past(resetCode) && inputCodes[2] == $past(resetCode))
		else $error("reset edge did not load the reset code");

	// No strobe copy while the reset pin is low: DAC registers hold
	chk_strobe_blocked: assert property (!pinsSync.resetN && !loadRst &&
		!(chanWrite.valid && chanWrite.update) |=> $stable(dacCode))
		else $error("load strobe acted under reset");

	// Power-up code follows the level select
	chk_por_level: assert property ($rose(porDone) |->
		dacCode[3] == ($past(pinsSync.levelSel) ? midCode : CODE_ZERO))
		else $error("power-up code wrong");

	// Power-up stays pending while the reset pin is low
	chk_por_wait: assert property (!porDone && !pinsSync.resetN |=> !porDone)
		else $error("power-up finished under reset");

	// Written codes stay inside the variant range
	chk_code_range: assert property (chanWr[0] |=>
		(inputCodes[0] & ~$past(codeMask)) == CODE_ZERO)
		else $error("code outside variant range");

	// Full frame close hands the word over next cycle
	chk_word_out: assert property (wordDone |=> wordValid && wordData == $past(shiftReg_r))
		else $error("word not handed over");

endmodule : qdsp_serial_ctrl

// File: verif/qdsp_host_model.sv
// Host model: drives serial frames and watches the serial output
`timescale 1ns/1ns
module qdsp_host_model
	import qdsp_pkg::*;
(
	// Clock
	input  wire logic clk_sys,
	// Serial pins
	output logic      sclk,
	output logic      frameSyncN,
	output logic      dataOut,
	input  wire logic dataBack
);
	////////////////////////////////////////////////////////////////
	// Idle pins: clock high and still, frame closed
	initial begin
		sclk       = 1'b1;
		frameSyncN = 1'b1;
		dataOut    = 1'b0;
	end

	// Wait n system clocks, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	// One frame of n bits, MSB first; got holds the bits seen on the output
	task automatic frame(input qdsp_word_t w, input int n, output qdsp_word_t got);
		got = '0;
		frameSyncN = 1'b0;                      // Open the frame
		for (int i = 0; i < n; i++) begin
			dataOut = w[FRAME_BITS-1-i];         // One bit per falling edge
			tick(10);
			got  = {got[FRAME_BITS-2:0], dataBack}; // Sampled before the fall
			sclk = 1'b0;                         // 160 ns period, far below 50 MHz
			tick(10);
			sclk = 1'b1;
		end
		tick(10);
		frameSyncN = 1'b1;                      // Close the frame
		dataOut    = ~dataOut;                  // Released line shows no stale bit
		tick(10);
	endtask : frame
endmodule : qdsp_host_model

// File: verif/quad_dac_serial_pin_control_tb_top.sv
// Testbench for the quad DAC serial pin control
`timescale 1ns/1ns
module quad_dac_serial_pin_control_tb_top
	import qdsp_pkg::*;
;
	logic clk_sys = 1'b0, rst_n, load_dac_n, resetPinN, levelSel, spanSelect, variant12;
	logic sclk, frameSyncN, dataIn, dataOut, wordValid, readbackLoad, spanDouble, porDone;
	qdsp_wr_t                chanWrite;    // Decoder write request
	qdsp_word_t              wordData, readbackWord, w0, w1, got;
	qdsp_code_t [NUM_CH-1:0] dacCode;      // DAC registers seen
	logic [NUM_CH-1:0]       inputPending; // New-data flags seen
	qdsp_code_t              inExp[NUM_CH], dacExp[NUM_CH], c;
	logic [NUM_CH-1:0]       pendExp;      // Expected new-data flags
	int                      error_cnt = 0, cmp_count = 0, validCnt = 0, n;

	always #4 clk_sys = ~clk_sys;          // 125 MHz
	always @(posedge clk_sys) if (wordValid === 1'b1) validCnt++; // Count closed words

	qdsp_host_model host (.clk_sys(clk_sys), .sclk(sclk), .frameSyncN(frameSyncN),
		.dataOut(dataIn), .dataBack(dataOut));

	qdsp_serial_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
		.frameSyncN(frameSyncN), .serial_data_in(dataIn), .serial_data_out(dataOut),
		.load_dac_n(load_dac_n), .resetPinN(resetPinN), .reset_level_select(levelSel),
		.spanSelect(spanSelect), .variant12(variant12), .wordValid(wordValid),
		.wordData(wordData), .chanWrite(chanWrite), .readbackLoad(readbackLoad),
		.readbackWord(readbackWord), .dacCode(dacCode), .inputPending(inputPending),
		.spanDouble(spanDouble), .porDone(porDone));

	////////////////////////////////////////////////////////////////
	// Compare, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	////////////////////////////////////////////////////////////////
	// Model: reset load, writes, transfers
	task automatic rstLoad();
		for (int k = 0; k < NUM_CH; k++) begin
			inExp[k]  = levelSel ? (variant12 ? CODE_MID_12 : CODE_MID_16) : CODE_ZERO;
			dacExp[k] = inExp[k];
		end
		pendExp = '0;
	endtask : rstLoad

	task automatic wr(input logic [NUM_CH-1:0] m, input qdsp_code_t v);
		chanWrite = '{valid: 1'b1, chanMask: m, update: 1'b0, code: v};
		tick(1);
		chanWrite.valid = 1'b0;
		for (int k = 0; k < NUM_CH; k++) if (m[k]) begin
			inExp[k]   = v & (variant12 ? CODE_MASK_12 : CODE_MASK_16);
			pendExp[k] = 1'b1;
		end
	endtask : wr

	task automatic xfer();
		for (int k = 0; k < NUM_CH; k++) if (pendExp[k]) dacExp[k] = inExp[k];
		pendExp = '0;
	endtask : xfer

	task automatic chkDac();
		for (int k = 0; k < NUM_CH; k++) chk(dacCode[k], dacExp[k]);
		chk(inputPending, pendExp);
	endtask : chkDac

	task automatic pulse();
		load_dac_n = 1'b0;
		tick(5);
		load_dac_n = 1'b1;
		tick(5);
	endtask : pulse

	////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the expected 18 us
	initial begin
		#400000;
		error_cnt++;
		give_verdict();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h109D));
		{rst_n, load_dac_n, resetPinN, levelSel, spanSelect, variant12} = 6'b010100;
		{chanWrite, readbackLoad, readbackWord} = '0;
		tick(20);
		rst_n = 1'b1;
		// Power-on waits for the reset pin
		tick(30);
		chk(porDone, 1'b0);
		resetPinN = 1'b1;
		tick(10);
		chk(porDone, 1'b1);
		rstLoad();
		chkDac();
		$display("test power_on done");
		// Frames, daisy output, short frame, readback
		w0 = qdsp_word_t'($urandom);
		w1 = qdsp_word_t'($urandom);
		host.frame(w0, 24, got);
		chk(wordData, w0);
		n = validCnt;
		host.frame(w1, 24, got);
		chk(validCnt, n + 1);
		chk(wordData, w1);
		chk(got, w0);
		host.frame(w0, 23, got);
		chk(validCnt, n + 1);
		chk(wordData, w1);
		readbackWord = qdsp_word_t'($urandom);
		readbackLoad = 1'b1;
		tick(1);
		readbackLoad = 1'b0;
		tick(2);
		host.frame(w0, 24, got);
		chk(got, readbackWord);
		$display("test frames done");
		// Reset pin: zero, 12-bit midscale, 16-bit midscale
		for (int i = 0; i < 3; i++) begin
			levelSel  = (i != 0);
			variant12 = (i == 1);
			tick(5);
			wr(4'hF, qdsp_code_t'($urandom));
			resetPinN = 1'b0;
			tick(8);
			rstLoad();
			chkDac();
			c = qdsp_code_t'($urandom) | 16'hF000;
			wr(4'hF, c);
			pulse();
			chkDac();
			resetPinN = 1'b1;
			tick(5);
			pulse();
			xfer();
			chkDac();
		end
		$display("test reset_pin done");
		// Load strobe held low
		load_dac_n = 1'b0;
		c = qdsp_code_t'($urandom);
		wr(4'h5, c);
		tick(4);
		xfer();
		chkDac();
		wr(4'hA, ~c);
		tick(4);
		xfer();
		chkDac();
		load_dac_n = 1'b1;
		$display("test load_held done");
		// Span select
		for (int s = 0; s < 2; s++) begin
			spanSelect = s[0];
			tick(5);
			chk(spanDouble, s[0]);
		end
		$display("test span done");
		// Write with update bit: pending code moves, new code waits
		wr(4'h8, c);
		tick(1);
		chanWrite = '{valid: 1'b1, chanMask: 4'h8, update: 1'b1, code: ~c};
		tick(1);
		chanWrite.valid = 1'b0;
		dacExp[3] = inExp[3];
		inExp[3]  = ~c;
		chkDac();
		$display("test write_update done");
		give_verdict();
	end
endmodule : quad_dac_serial_pin_control_tb_top
